// ### verilog/sbs_pkg.sv
// package for the synchronous burst sram port
package sbs_pkg;
  localparam int ADDR_W    = 8;
  localparam int LANES     = 4;
  localparam int DATA_W    = 32;
  localparam int DEPTH     = 256;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [1:0] BURST_ONE = 2'h1;

  // operation state of the port
  typedef enum logic [2:0] {
    SBS_DESEL = 3'b001,
    SBS_READ  = 3'b010,
    SBS_WRITE = 3'b100
  } sbs_state_t;

  // synchronous control inputs sampled at the clock edge
  typedef struct packed {
    logic             proc_addr_strobe_n;
    logic             ctrl_addr_strobe_n;
    logic             burst_advance_n;
    logic             byte_write_enable_n;
    logic             global_write_n;
    logic [LANES-1:0] lane_write_select_n;
    logic             chip_select_a_n;
    logic             chip_select_b;
    logic             chip_select_c_n;
  } sbs_ctrl_t;
endpackage

// ### verilog/sbs_port.sv
// synchronous flow-through burst sram core with strobe and burst logic
`timescale 1ns/1ps
module sbs_port (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  // synchronous control and address
  input  wire sbs_pkg::sbs_ctrl_t           ctrl,
  input  wire logic [sbs_pkg::ADDR_W-1:0]   addr,
  // asynchronous pins
  input  wire logic                         out_enable_n,
  input  wire logic                         sleep_request,
  input  wire logic                         burst_order_strap,
  // data and parity lines
  input  wire logic [sbs_pkg::DATA_W-1:0]   data_in,
  output logic      [sbs_pkg::DATA_W-1:0]   data_out,
  output logic      [sbs_pkg::DATA_W-1:0]   data_oe_n,
  input  wire logic [sbs_pkg::LANES-1:0]    parity_in,
  output logic      [sbs_pkg::LANES-1:0]    parity_lines,
  output logic      [sbs_pkg::LANES-1:0]    parity_oe_n,
  // status
  output logic                              sleeping
);
  localparam int AW = sbs_pkg::ADDR_W;
  localparam int LN = sbs_pkg::LANES;
  localparam int DW = sbs_pkg::DATA_W;

  // storage, data and parity per lane
  logic [7:0] mem_q [sbs_pkg::DEPTH][LN];
  logic       par_q [sbs_pkg::DEPTH][LN];

  // pin synchronisers for asynchronous pins
  logic [2:0] oe_s_q, oe_s_d, slp_s_q, slp_s_d, md_s_q, md_s_d;
  logic       oe_q, oe_d, slp_q, slp_d, md_q, md_d;

  // port state
  sbs_pkg::sbs_state_t st_q, st_d;
  logic [AW-1:0] base_q, base_d;
  logic [1:0]    cnt_q, cnt_d;
  logic          first_q, first_d;
  logic [DW-1:0] din_q, din_d;
  logic [LN-1:0] pin_q, pin_d;
  logic [DW-1:0] dout_q, dout_d;
  logic [LN-1:0] pout_q, pout_d;
  logic          drive_q, drive_d;
  logic          sleep_q, sleep_d;

  logic [1:0]    nx_pos;
  logic [AW-1:0] nx_addr;
  logic          sel, take_p, take_c, take, is_wr;
  logic [LN-1:0] lane_we;

  // select and strobe qualification
  always_comb begin
    sel    = !ctrl.chip_select_a_n && ctrl.chip_select_b && !ctrl.chip_select_c_n;
    take_p = !ctrl.proc_addr_strobe_n && !ctrl.chip_select_a_n;
    take_c = !ctrl.ctrl_addr_strobe_n && !take_p;
    take   = (take_p || take_c) && !slp_q;
    // write qualification, processor-strobe cycle ignores write inputs
    for (int i = 0; i < LN; i++) begin
      lane_we[i] = !ctrl.global_write_n
                || (!ctrl.byte_write_enable_n && !ctrl.lane_write_select_n[i]);
    end
    is_wr = |lane_we && !(take_p) && !slp_q;
  end

  // next state of synchronisers, state, counter and data path
  always_comb begin
    oe_s_d = {oe_s_q[1:0], out_enable_n};
    slp_s_d = {slp_s_q[1:0], sleep_request};
    md_s_d = {md_s_q[1:0], burst_order_strap};
    oe_d   = (oe_s_q[2] == oe_s_q[1]) ? oe_s_q[2] : oe_q;
    slp_d  = (slp_s_q[2] == slp_s_q[1]) ? slp_s_q[2] : slp_q;
    md_d   = (md_s_q[2] == md_s_q[1]) ? md_s_q[2] : md_q;
    st_d    = st_q;
    base_d  = base_q;
    cnt_d   = cnt_q;
    first_d = 1'b0;
    din_d   = data_in;
    pin_d   = parity_in;
    sleep_d = slp_q;
    if (take) begin
      if (sel) begin
        base_d  = addr;
        cnt_d   = sbs_pkg::BURST_RST;
        first_d = (st_q == sbs_pkg::SBS_DESEL);
        st_d    = (take_c && is_wr) ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
      end else begin
        st_d = sbs_pkg::SBS_DESEL;
      end
    end else if (!slp_q && st_q != sbs_pkg::SBS_DESEL) begin
      if (!ctrl.burst_advance_n) begin
        cnt_d = cnt_q + sbs_pkg::BURST_ONE;
      end
      st_d = is_wr ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
    end
  end

  // flow-through read data for the location the next cycle presents
  always_comb begin
    // burst order from strap: xor for interleaved, add for linear
    nx_pos  = md_q ? (base_d[1:0] ^ cnt_d) : (base_d[1:0] + cnt_d);
    nx_addr = {base_d[AW-1:2], nx_pos};
    for (int i = 0; i < LN; i++) begin
      dout_d[i*8 +: 8] = mem_q[nx_addr][i];
      pout_d[i]        = par_q[nx_addr][i];
    end
    // first cycle out of deselect floats whatever output enable says
    drive_d = (st_d == sbs_pkg::SBS_READ) && !slp_d && !first_d
           && !oe_d;
  end

  // register the control state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oe_s_q  <= 3'h7;
      slp_s_q <= 3'h0;
      md_s_q  <= 3'h7;
      oe_q    <= 1'b1;
      slp_q   <= 1'b0;
      md_q    <= 1'b1;
      st_q    <= sbs_pkg::SBS_DESEL;
      base_q  <= '0;
      cnt_q   <= sbs_pkg::BURST_RST;
      first_q <= 1'b0;
      din_q   <= '0;
      pin_q   <= '0;
      dout_q  <= '0;
      pout_q  <= '0;
      drive_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      oe_s_q  <= oe_s_d;
      slp_s_q <= slp_s_d;
      md_s_q  <= md_s_d;
      oe_q    <= oe_d;
      slp_q   <= slp_d;
      md_q    <= md_d;
      st_q    <= st_d;
      base_q  <= base_d;
      cnt_q   <= cnt_d;
      first_q <= first_d;
      din_q   <= din_d;
      pin_q   <= pin_d;
      dout_q  <= dout_d;
      pout_q  <= pout_d;
      drive_q <= drive_d;
      sleep_q <= sleep_d;
    end
  end

  // self-timed write of the registered data, one cycle after capture
  logic          wr_pend_q;
  logic [LN-1:0] wr_lane_q;
  logic [AW-1:0] wr_addr_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_lane_q <= '0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= (st_d == sbs_pkg::SBS_WRITE);
      wr_lane_q <= lane_we;
      wr_addr_q <= nx_addr;
    end
  end

  // memory array, per-lane write with parity tied to its lane
  always_ff @(posedge sys_clk) begin
    if (wr_pend_q) begin
      for (int i = 0; i < LN; i++) begin
        if (wr_lane_q[i]) begin
          mem_q[wr_addr_q][i] <= din_q[i*8 +: 8];
          par_q[wr_addr_q][i] <= pin_q[i];
        end
      end
    end
  end

  // outputs, straight from flip-flops
  always_comb begin
    data_out     = dout_q;
    parity_lines = pout_q;
    data_oe_n    = {DW{!drive_q}};
    parity_oe_n  = {LN{!drive_q}};
    sleeping     = sleep_q;
  end

  // checks
  chk_strobe_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
    (take_p && sel && !slp_q) |=> (base_q == $past(addr)) && cnt_q == 2'h0)
    else $error("processor strobe did not capture address");
  chk_ce_ignore: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ctrl.chip_select_a_n && ctrl.ctrl_addr_strobe_n && !slp_q) |=> $stable(base_q))
    else $error("strobe acted while first select high");
  chk_prio_proc: assert property (@(posedge sys_clk) disable iff (!nrst)
    (take && !ctrl.proc_addr_strobe_n && !ctrl.chip_select_a_n && sel) |=>
    st_q == sbs_pkg::SBS_READ)
    else $error("controller strobe won over processor strobe");
  chk_burst_adv: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!take && !slp_q && st_q != sbs_pkg::SBS_DESEL && !ctrl.burst_advance_n)
    |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("burst counter did not advance");
  chk_burst_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!take && ctrl.burst_advance_n) |=> $stable(cnt_q))
    else $error("burst counter moved while idle");
  chk_desel_float: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q != sbs_pkg::SBS_READ) |-> data_oe_n == {DW{1'b1}})
    else $error("outputs driven outside read");
  chk_oe_float: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == sbs_pkg::SBS_READ && !first_q && oe_q) |-> &parity_oe_n)
    else $error("outputs driven with output enable high");
  chk_desel_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    (take && !sel) |=> st_q == sbs_pkg::SBS_DESEL)
    else $error("unselected strobe did not deselect");
  chk_sleep_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
    slp_q |=> sleeping)
    else $error("sleep not reflected");
  chk_first_float: assert property (@(posedge sys_clk) disable iff (!nrst)
    first_q |-> &data_oe_n && &parity_oe_n)
    else $error("outputs driven in first cycle after deselect");
  cov_first: cover property (@(posedge sys_clk) disable iff (!nrst) first_q);
  cov_read: cover property (@(posedge sys_clk) disable iff (!nrst) st_q == sbs_pkg::SBS_READ);
  cov_write: cover property (@(posedge sys_clk) disable iff (!nrst) st_q == sbs_pkg::SBS_WRITE);
  cov_wrap: cover property (@(posedge sys_clk) disable iff (!nrst) cnt_q == 2'h3 ##1 cnt_q == 2'h0);
endmodule

// ### test/sbs_host.sv
// bus master model driving the sram port pins
`timescale 1ns/1ps
module sbs_host (
  // clock
  input  wire logic          sys_clk,
  // port outputs
  input  wire logic [31:0]   data_out,
  input  wire logic [31:0]   data_oe_n,
  input  wire logic [3:0]    parity_lines,
  input  wire logic [3:0]    parity_oe_n,
  // master pins
  output sbs_pkg::sbs_ctrl_t ctrl,
  output logic      [7:0]    addr,
  output logic      [31:0]   data_in,
  output logic      [3:0]    parity_in,
  output logic               out_enable_n,
  output logic               sleep_request,
  output logic               burst_order_strap
);
  logic        drv;
  logic [35:0] dv;
  logic [35:0] pin;
  logic [35:0] last_q;
  // wire level: master, else port, else inverse of last level
  assign pin = drv ? dv : ({parity_lines, data_out} & ~{parity_oe_n, data_oe_n})
                        | (~last_q & {parity_oe_n, data_oe_n});
  assign {parity_in, data_in} = pin;
  // last level seen on the wire
  always @(posedge sys_clk) last_q <= pin;
  // idle bus at time zero
  initial begin
    ctrl = '1;
    addr = 8'h00;
    dv = 36'h0;
    drv = 1'b0;
    last_q = 36'h0;
    out_enable_n = 1'b0;
    sleep_request = 1'b0;
    burst_order_strap = 1'b1;
  end
  // one bus cycle, results settled after the rising edge
  task automatic op(sbs_pkg::sbs_ctrl_t c, logic [7:0] a, logic [35:0] d, logic w);
    @(negedge sys_clk);
    ctrl = c;
    addr = a;
    dv = d;
    drv = w;
    @(posedge sys_clk);
    #1;
  endtask
  // static pins; the strap moves only under reset
  task automatic pins(logic o, logic z, logic m);
    @(negedge sys_clk);
    out_enable_n = o;
    sleep_request = z;
    burst_order_strap = m;
  endtask
endmodule

// ### test/tb.sv
// testbench of the sram port with random burst traffic
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  localparam sbs_pkg::sbs_ctrl_t IDLE = 12'hFFA;
  localparam sbs_pkg::sbs_ctrl_t STEP = 12'hDFA;
  logic               sys_clk = 1'b0;
  logic               nrst = 1'b0;
  logic [31:0]        seed = 32'h20A42F82;
  int                 failures = 0;
  int                 tests_run = 0;
  logic [35:0]        mem_m [256];
  logic [7:0]         ga;
  sbs_pkg::sbs_ctrl_t ctrl;
  logic [7:0]         addr;
  logic [31:0]        data_in, data_out, data_oe_n;
  logic [3:0]         parity_in, parity_lines, parity_oe_n;
  logic               oe_n, slp, strap, sleeping;
  // 20 MHz clock
  initial forever #25 sys_clk = ~sys_clk;
  sbs_port sbs_port_i (.sys_clk(sys_clk), .nrst(nrst), .ctrl(ctrl), .addr(addr),
    .out_enable_n(oe_n), .sleep_request(slp), .burst_order_strap(strap),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .parity_in(parity_in),
    .parity_lines(parity_lines), .parity_oe_n(parity_oe_n), .sleeping(sleeping));
  sbs_host sbs_host_i (.sys_clk(sys_clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .parity_lines(parity_lines), .parity_oe_n(parity_oe_n), .ctrl(ctrl), .addr(addr),
    .data_in(data_in), .parity_in(parity_in), .out_enable_n(oe_n),
    .sleep_request(slp), .burst_order_strap(strap));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // control word: strobes, advance, byte enable, global, lanes, selected
  function automatic sbs_pkg::sbs_ctrl_t mk(int p, c, v, b, g, logic [3:0] l, int s);
    return '{1'(p), 1'(c), 1'(v), 1'(b), 1'(g), l, ~1'(s), 1'(s), ~1'(s)};
  endfunction
  // burst address k steps on, interleaved when s is high
  function automatic logic [7:0] nb(logic [7:0] a, int k, logic s);
    return {a[7:2], s ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction
  // bits a write touches, parity with its lane
  function automatic logic [35:0] wmask(sbs_pkg::sbs_ctrl_t c);
    logic [3:0] l;
    l = !c.global_write_n ? 4'hF : (!c.byte_write_enable_n ? ~c.lane_write_select_n : 4'h0);
    return {l, {8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  // write random data and update the model
  task automatic wr(logic [7:0] a, sbs_pkg::sbs_ctrl_t c);
    logic [35:0] d;
    logic [35:0] m;
    d = {4'(rnd()), rnd()};
    m = wmask(c);
    mem_m[a] = (mem_m[a] & ~m) | (d & m);
    sbs_host_i.op(c, a, d, 1'b1);
    `CHK("write oe", 36'hF_FFFF_FFFF, {parity_oe_n, data_oe_n})
  endtask
  // one cycle, then expect location e driven
  task automatic rd(sbs_pkg::sbs_ctrl_t c, logic [7:0] a, logic [7:0] e);
    sbs_host_i.op(c, a, 36'h0, 1'b0);
    `CHK("read data", mem_m[e], {parity_lines, data_out})
    `CHK("read oe", 36'h0, {parity_oe_n, data_oe_n})
  endtask
  // fill a group, byte write one word, read it back as a burst
  task automatic grp(logic s);
    logic [3:0] l;
    ga = 8'(rnd());
    l = 4'(rnd()) & 4'hE;
    for (int k = 0; k < 4; k++) wr({ga[7:2], 2'(k)}, mk(1, 0, 1, 1, 0, 4'h0, 1));
    wr(ga, mk(1, 0, 1, 0, 1, l, 1));
    repeat (2) sbs_host_i.op(IDLE, ga, 36'h0, 1'b0);
    rd(mk(0, 0, 1, 1, 0, 4'hF, 1), ga, ga);
    for (int k = 1; k < 5; k++) rd(STEP, ga, nb(ga, k, s));
    rd(IDLE, ga, ga);
    rd(mk(0, 1, 1, 1, 1, 4'hF, 0), ~ga, ga);
    rd(mk(1, 0, 1, 1, 1, 4'h0, 1), ga ^ 8'h3, ga ^ 8'h3);
    sbs_host_i.op(mk(1, 0, 1, 1, 1, 4'hF, 0), ga, 36'h0, 1'b0);
    `CHK("desel oe", 36'hF_FFFF_FFFF, {parity_oe_n, data_oe_n})
    sbs_host_i.op(mk(0, 1, 1, 1, 1, 4'hF, 1), ga, 36'h0, 1'b0);
    `CHK("first oe", 36'hF_FFFF_FFFF, {parity_oe_n, data_oe_n})
    `CHK("first data", mem_m[ga], {parity_lines, data_out})
    rd(IDLE, ga, ga);
    sbs_host_i.pins(1'b1, 1'b0, s);
    repeat (4) sbs_host_i.op(STEP, ga, 36'h0, 1'b0);
    `CHK("oe high", 36'hF_FFFF_FFFF, {parity_oe_n, data_oe_n})
    sbs_host_i.pins(1'b0, 1'b0, s);
    $display("burst group done");
  endtask
  // counts and verdict
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence: interleaved run, sleep, reset, linear run
  initial begin
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    sbs_host_i.op(IDLE, 8'h00, 36'h0, 1'b0);
    `CHK("reset oe", 36'hF_FFFF_FFFF, {parity_oe_n, data_oe_n})
    repeat (6) grp(1'b1);
    sbs_host_i.pins(1'b0, 1'b1, 1'b1);
    repeat (4) sbs_host_i.op(IDLE, ga, 36'h0, 1'b0);
    `CHK("sleep", 1'b1, sleeping)
    sbs_host_i.pins(1'b0, 1'b0, 1'b1);
    repeat (4) sbs_host_i.op(IDLE, ga, 36'h0, 1'b0);
    `CHK("awake", 1'b0, sleeping)
    rd(mk(0, 1, 1, 1, 1, 4'hF, 1), ga, ga);
    $display("sleep test done");
    nrst = 1'b0;
    sbs_host_i.pins(1'b0, 1'b0, 1'b0);
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (6) grp(1'b0);
    end_sim();
  end
endmodule
